// ### verilog/irc_ctrl.sv
// control registers and paths of the isochronous rate converters
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// R1: each converter path takes the core source picked by its own source-select code.
// R2: software only connects sources running at the rate of the converter side they feed.
// R3: converter one high-rate select at bits 14:11, codes 0-2 system, 8-9 async, rest reserved.
// R4: converter one low-rate select at bits 14:11 of the next register, same codes, reset zero.
// R5: software only selects rates between 8kHz and 192kHz.
// R6: software keeps both rate selects of a converter in the same clock domain.
// R7: software clears the decimation source selects before changing the high-rate select.
// R8: software clears the interpolation source selects before changing the low-rate select.
// R9: bits 15 to 12 of the third register enable interpolation paths one to four, reset off.
// R10: bits 9 to 6 of the third register enable decimation paths one to four, reset off.
// R11: bit 0 of the third register enables the notch filter, reset off, and should be set.
// R12: converter two has its own high-rate select with the same codes in the following register.
// R13: software waits 125us after clearing source selects before writing a rate select.
// R14: software keeps the higher rate an integer multiple of the lower, ratio up to 24.
// R15: enabling a path fails when the clock budget is short, leaving active paths alone.
// R16: every rate field and enable bit reads back what software last wrote.
module irc_ctrl
(
   input  wire logic                                              CORE_CLK,
   input  wire logic                                              RST,
   input  wire logic                                              REG_WR,
   input  wire logic                                              REG_RD,
   input  wire logic [11:0]                                       REG_ADDR,
   input  wire logic [15:0]                                       REG_WDATA,
   output logic      [15:0]                                       REG_RDATA,
   output logic                                                   REG_RVALID,
   input  wire logic                                              CLK_BUDGET_OK,
   input  wire logic [irc_pkg::NUM_PATHS*8-1:0]                   PATH_SRC_SEL,
   input  wire logic [irc_pkg::NUM_SOURCES*irc_pkg::SAMPLE_W-1:0] SRC_DATA,
   output irc_pkg::irc_conv_cfg_s                                 CONV1_CFG,
   output logic      [3:0]                                        CONV2_HIGH_RATE_SEL,
   output logic                                                   CONV1_RATE_ERR,
   output logic      [irc_pkg::NUM_PATHS-1:0]                     PATH_ACTIVE,
   output logic      [irc_pkg::NUM_PATHS*irc_pkg::SAMPLE_W-1:0]   PATH_DATA
);
   // ****************************************
   // register storage
   // ****************************************
   logic [3:0]  conv1_high_rate_sel;
   logic [3:0]  conv1_low_rate_sel;
   logic [3:0]  conv2_high_rate_sel;
   logic [15:0] conv1_path_enable_ctrl;
   logic [15:0] next_rdata;

   wire wr_c1h = REG_WR && REG_ADDR == irc_pkg::CONV1_HIGH_RATE_CTRL_OFS;
   wire wr_c1l = REG_WR && REG_ADDR == irc_pkg::CONV1_LOW_RATE_CTRL_OFS;
   wire wr_c1e = REG_WR && REG_ADDR == irc_pkg::CONV1_PATH_ENABLE_CTRL_OFS;
   wire wr_c2h = REG_WR && REG_ADDR == irc_pkg::CONV2_HIGH_RATE_CTRL_OFS;

   // only documented bits are stored; the rest read as zero
   wire [15:0] enable_mask = 16'hf3c1;
   wire [3:0]  wr_rate = REG_WDATA[irc_pkg::RATE_SEL_MSB:irc_pkg::RATE_SEL_LSB];

   always_ff @(posedge CORE_CLK)
   begin
      if (RST)
      begin
         conv1_high_rate_sel    <= irc_pkg::RATE_SEL_RESET; // R3
         conv1_low_rate_sel     <= irc_pkg::RATE_SEL_RESET; // R4
         conv2_high_rate_sel    <= irc_pkg::RATE_SEL_RESET; // R12
         conv1_path_enable_ctrl <= irc_pkg::CTRL_RESET; // R9 R10 R11
      end
      else
      begin
         // reserved codes are kept as written so readback stays honest
         if (wr_c1h)
         begin
            conv1_high_rate_sel <= wr_rate; // R3
         end
         if (wr_c1l)
         begin
            conv1_low_rate_sel <= wr_rate; // R4
         end
         if (wr_c2h)
         begin
            conv2_high_rate_sel <= wr_rate; // R12
         end
         if (wr_c1e)
         begin
            conv1_path_enable_ctrl <= REG_WDATA & enable_mask; // R9 R10 R11
         end
      end
   end

   // ****************************************
   // readback
   // ****************************************
   always_comb
   begin
      next_rdata = 16'h0000;
      if (REG_ADDR == irc_pkg::CONV1_HIGH_RATE_CTRL_OFS)
      begin
         next_rdata[irc_pkg::RATE_SEL_MSB:irc_pkg::RATE_SEL_LSB] = conv1_high_rate_sel; // R16
      end
      else if (REG_ADDR == irc_pkg::CONV1_LOW_RATE_CTRL_OFS)
      begin
         next_rdata[irc_pkg::RATE_SEL_MSB:irc_pkg::RATE_SEL_LSB] = conv1_low_rate_sel; // R16
      end
      else if (REG_ADDR == irc_pkg::CONV1_PATH_ENABLE_CTRL_OFS)
      begin
         next_rdata = conv1_path_enable_ctrl; // R16
      end
      else if (REG_ADDR == irc_pkg::CONV2_HIGH_RATE_CTRL_OFS)
      begin
         next_rdata[irc_pkg::RATE_SEL_MSB:irc_pkg::RATE_SEL_LSB] = conv2_high_rate_sel; // R16
      end
   end

   always_ff @(posedge CORE_CLK)
   begin
      if (RST)
      begin
         REG_RDATA  <= 16'h0000;
         REG_RVALID <= 1'b0;
      end
      else
      begin
         REG_RDATA  <= REG_RD ? next_rdata : 16'h0000;
         REG_RVALID <= REG_RD;
      end
   end

   // ****************************************
   // configuration out
   // ****************************************
   wire [15:0] en = conv1_path_enable_ctrl;
   assign CONV1_CFG.high_rate_sel   = conv1_high_rate_sel; // R3
   assign CONV1_CFG.low_rate_sel    = conv1_low_rate_sel; // R4
   // index 0 is path one, which sits at the top bit of each group
   assign CONV1_CFG.interp_en       = {en[12], en[13], en[14], en[15]}; // R9
   assign CONV1_CFG.decim_en        = {en[6], en[7], en[8], en[9]}; // R10
   assign CONV1_CFG.notch_filter_en = en[irc_pkg::NOTCH_EN_BIT]; // R11
   assign CONV2_HIGH_RATE_SEL       = conv2_high_rate_sel; // R12

   // flags a mixed-domain or reserved setting; software owns keeping it clear
   wire dom_mismatch = conv1_high_rate_sel[irc_pkg::RATE_DOMAIN_BIT]
                       ^ conv1_low_rate_sel[irc_pkg::RATE_DOMAIN_BIT];
   wire high_bad = !(conv1_high_rate_sel inside {irc_pkg::RATE_SYS1, irc_pkg::RATE_SYS2,
                     irc_pkg::RATE_SYS3, irc_pkg::RATE_ASYNC1, irc_pkg::RATE_ASYNC2});
   wire low_bad  = !(conv1_low_rate_sel inside {irc_pkg::RATE_SYS1, irc_pkg::RATE_SYS2,
                     irc_pkg::RATE_SYS3, irc_pkg::RATE_ASYNC1, irc_pkg::RATE_ASYNC2});
   assign CONV1_RATE_ERR = dom_mismatch | high_bad | low_bad; // R3 R4

   // ****************************************
   // converter paths: 0-3 interpolation, 4-7 decimation
   // ****************************************
   wire [irc_pkg::NUM_PATHS-1:0] path_req = {CONV1_CFG.decim_en, CONV1_CFG.interp_en};

   genvar g;
   generate
      for (g = 0; g < irc_pkg::NUM_PATHS; g = g + 1)
      begin : g_path
         irc_path u_path
         (
            .clk       (CORE_CLK),
            .rst       (RST),
            .en_req    (path_req[g]),
            .budget_ok (CLK_BUDGET_OK),
            .src_sel   (PATH_SRC_SEL[g*8 +: 8]),
            .src_data  (SRC_DATA),
            .active    (PATH_ACTIVE[g]),
            .sample    (PATH_DATA[g*irc_pkg::SAMPLE_W +: irc_pkg::SAMPLE_W])
         );
      end
   endgenerate
endmodule
`default_nettype wire

// ### include/irc_pkg.sv
// package: register map, field layout and types of the rate converter controls
`default_nettype none
package irc_pkg;
   // ****************************************
   // register offsets (register index on the control port)
   // ****************************************
   localparam logic [11:0] CONV1_HIGH_RATE_CTRL_OFS   = 12'h0ef0;
   localparam logic [11:0] CONV1_LOW_RATE_CTRL_OFS    = 12'h0ef1;
   localparam logic [11:0] CONV1_PATH_ENABLE_CTRL_OFS = 12'h0ef2;
   localparam logic [11:0] CONV2_HIGH_RATE_CTRL_OFS   = 12'h0ef3;

   // ****************************************
   // field positions and reset values
   // ****************************************
   localparam int RATE_SEL_LSB   = 11;
   localparam int RATE_SEL_MSB   = 14;
   localparam int INTERP_EN_MSB  = 15;
   localparam int INTERP_EN_LSB  = 12;
   localparam int DECIM_EN_MSB   = 9;
   localparam int DECIM_EN_LSB   = 6;
   localparam int NOTCH_EN_BIT   = 0;
   localparam logic [15:0] CTRL_RESET = 16'h0000;
   localparam logic [3:0]  RATE_SEL_RESET = 4'h0;

   // ****************************************
   // sizes and source codes
   // ****************************************
   localparam int NUM_PATHS     = 8;
   localparam int NUM_SOURCES   = 4;
   localparam int SAMPLE_W      = 24;
   localparam logic [7:0] SRC_NONE = 8'h00;
   localparam logic [23:0] SAMPLE_ZERO = 24'h00_0000;

   // rate codes; bit 3 marks the asynchronous clock domain
   typedef enum logic [3:0] {
      RATE_SYS1   = 4'h0,
      RATE_SYS2   = 4'h1,
      RATE_SYS3   = 4'h2,
      RATE_ASYNC1 = 4'h8,
      RATE_ASYNC2 = 4'h9
   } irc_rate_e;
   localparam int RATE_DOMAIN_BIT = 3;

   typedef struct packed {
      logic [3:0] high_rate_sel;
      logic [3:0] low_rate_sel;
      logic [3:0] interp_en;
      logic [3:0] decim_en;
      logic       notch_filter_en;
   } irc_conv_cfg_s;
endpackage
`default_nettype wire

// ### verilog/irc_path.sv
// one converter path: source selection and enable admission
`timescale 1ns/1ps
`default_nettype none
module irc_path
(
   input  wire logic                                         clk,
   input  wire logic                                         rst,
   input  wire logic                                         en_req,
   input  wire logic                                         budget_ok,
   input  wire logic [7:0]                                   src_sel,
   input  wire logic [irc_pkg::NUM_SOURCES*irc_pkg::SAMPLE_W-1:0] src_data,
   output logic                                              active,
   output logic      [irc_pkg::SAMPLE_W-1:0]                 sample
);
   logic                         en_req_d;
   logic                         next_active;
   logic [irc_pkg::SAMPLE_W-1:0] picked;
   wire                          attempt = en_req & ~en_req_d;
   wire  [7:0]                   src_idx = src_sel - 8'h01;

   // ****************************************
   // admission
   // ****************************************
   // a refused attempt stays off until software clears and sets the bit again
   assign next_active = en_req & (active | (attempt & budget_ok)); // R15

   // ****************************************
   // source selection
   // ****************************************
   // unknown or zero codes feed silence rather than stale data
   assign picked = (src_sel == irc_pkg::SRC_NONE || src_sel > 8'(irc_pkg::NUM_SOURCES))
                   ? irc_pkg::SAMPLE_ZERO
                   : src_data[src_idx[1:0]*irc_pkg::SAMPLE_W +: irc_pkg::SAMPLE_W]; // R1

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         en_req_d <= 1'b0;
         active   <= 1'b0;
         sample   <= irc_pkg::SAMPLE_ZERO;
      end
      else
      begin
         en_req_d <= en_req;
         active   <= next_active;
         sample   <= next_active ? picked : irc_pkg::SAMPLE_ZERO; // R1
      end
   end
endmodule
`default_nettype wire

// ### dv/irc_ctrl_monitor.sv
// checker: register port and path admission properties
`timescale 1ns/1ps
`default_nettype none
module irc_ctrl_monitor
(
   input wire logic                   CORE_CLK,
   input wire logic                   RST,
   input wire logic                   REG_WR,
   input wire logic                   REG_RD,
   input wire logic [11:0]            REG_ADDR,
   input wire logic [15:0]            REG_WDATA,
   input wire logic [15:0]            REG_RDATA,
   input wire logic                   REG_RVALID,
   input wire logic                   CLK_BUDGET_OK,
   input wire logic [63:0]            PATH_SRC_SEL,
   input wire logic [95:0]            SRC_DATA,
   input wire irc_pkg::irc_conv_cfg_s CONV1_CFG,
   input wire logic [3:0]             CONV2_HIGH_RATE_SEL,
   input wire logic                   CONV1_RATE_ERR,
   input wire logic [7:0]             PATH_ACTIVE,
   input wire logic [191:0]           PATH_DATA
);
   // ****
   // helper state
   // ****
   logic [15:0] wd_q;
   logic [7:0]  sel_q;
   logic [23:0] src_q;
   wire         wr_hi = REG_WR && REG_ADDR == irc_pkg::CONV1_HIGH_RATE_CTRL_OFS;
   wire         wr_lo = REG_WR && REG_ADDR == irc_pkg::CONV1_LOW_RATE_CTRL_OFS;
   wire         wr_en = REG_WR && REG_ADDR == irc_pkg::CONV1_PATH_ENABLE_CTRL_OFS;
   wire         wr_c2 = REG_WR && REG_ADDR == irc_pkg::CONV2_HIGH_RATE_CTRL_OFS;
   always_ff @(posedge CORE_CLK)
   begin
      {wd_q, sel_q, src_q} <= {REG_WDATA, PATH_SRC_SEL[7:0], SRC_DATA[23:0]};
   end
   // ****
   // properties
   // ****
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (RST);
   // admission judged on the rising edge of the enable only
   sequence s_attempt;
      $rose(CONV1_CFG.interp_en[0]) && CLK_BUDGET_OK;
   endsequence
   sequence s_refused;
      $rose(CONV1_CFG.interp_en[0]) && !CLK_BUDGET_OK;
   endsequence
   a_high_sel_wr: assert property (wr_hi |=> CONV1_CFG.high_rate_sel == wd_q[14:11])
      else $error("high rate select not taken");
   a_low_sel_wr: assert property (wr_lo |=> CONV1_CFG.low_rate_sel == wd_q[14:11])
      else $error("low rate select not taken");
   a_path_en_wr: assert property (wr_en |=> {CONV1_CFG.interp_en, CONV1_CFG.decim_en} ==
      {wd_q[12], wd_q[13], wd_q[14], wd_q[15], wd_q[6], wd_q[7], wd_q[8], wd_q[9]})
      else $error("path enables not taken");
   a_notch_wr: assert property (wr_en |=> CONV1_CFG.notch_filter_en == wd_q[0])
      else $error("notch enable not taken");
   a_conv2_sel_wr: assert property (wr_c2 |=> CONV2_HIGH_RATE_SEL == wd_q[14:11])
      else $error("second converter select not taken");
   a_cfg_hold_idle: assert property (!REG_WR |=> $stable(CONV1_CFG)
      && $stable(CONV2_HIGH_RATE_SEL))
      else $error("configuration changed without a write");
   a_read_answer: assert property (REG_RD |=> REG_RVALID)
      else $error("read not answered");
   a_admit_ok: assert property (s_attempt |=> PATH_ACTIVE[0])
      else $error("path not admitted");
   a_admit_refused: assert property (s_refused |=> !PATH_ACTIVE[0])
      else $error("path admitted without budget");
   a_active_kept: assert property (PATH_ACTIVE[0] && CONV1_CFG.interp_en[0]
      |=> PATH_ACTIVE[0])
      else $error("active path dropped");
   a_path_src_data: assert property (PATH_ACTIVE[0] && sel_q == 8'h01
      |-> PATH_DATA[23:0] == src_q)
      else $error("path data not from selected source");
endmodule
bind irc_ctrl irc_ctrl_monitor u_mon (.CORE_CLK, .RST, .REG_WR, .REG_RD, .REG_ADDR, .REG_WDATA,
   .REG_RDATA, .REG_RVALID, .CLK_BUDGET_OK, .PATH_SRC_SEL, .SRC_DATA, .CONV1_CFG,
   .CONV2_HIGH_RATE_SEL, .CONV1_RATE_ERR, .PATH_ACTIVE, .PATH_DATA);
`default_nettype wire

// ### dv/irc_ctrl_tb.sv
// testbench: register access and path admission of the rate converter controls
`timescale 1ns/1ps
`default_nettype none
module irc_ctrl_tb;
   logic                   core_clk = 1'b0;
   logic                   rst = 1'b1;
   logic                   reg_wr = 1'b0;
   logic                   reg_rd = 1'b0;
   logic [11:0]            reg_addr = 12'h000;
   logic [15:0]            reg_wdata = 16'h0000;
   logic [15:0]            reg_rdata;
   logic                   reg_rvalid;
   logic                   clk_budget_ok = 1'b1;
   logic [63:0]            path_src_sel = '0;
   logic [95:0]            src_data = '0;
   irc_pkg::irc_conv_cfg_s conv1_cfg;
   logic [3:0]             conv2_high_rate_sel;
   logic                   conv1_rate_err;
   logic [7:0]             path_active;
   logic [191:0]           path_data;
   // 125us of quiet source selects at 8ns per cycle
   localparam int          SRC_CLEAR_WAIT = 15625;
   int                     miscompares = 0;
   int                     checked = 0;
   irc_ctrl u_dut (.CORE_CLK(core_clk), .RST(rst), .REG_WR(reg_wr), .REG_RD(reg_rd),
      .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata),
      .REG_RVALID(reg_rvalid), .CLK_BUDGET_OK(clk_budget_ok), .PATH_SRC_SEL(path_src_sel),
      .SRC_DATA(src_data), .CONV1_CFG(conv1_cfg), .CONV2_HIGH_RATE_SEL(conv2_high_rate_sel),
      .CONV1_RATE_ERR(conv1_rate_err), .PATH_ACTIVE(path_active), .PATH_DATA(path_data));
   always #4 core_clk = ~core_clk;
   // ****
   // bus tasks
   // ****
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      checked++;
      if (got !== exp)
      begin
         miscompares++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [15:0] d);
      @(posedge core_clk) #1;
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(posedge core_clk) #1;
      reg_wr = 1'b0;
   endtask
   // answer stands one cycle, so it is judged right after the read edge
   task automatic rd(input logic [11:0] a, input logic [15:0] exp);
      @(posedge core_clk) #1;
      reg_rd = 1'b1;
      reg_addr = a;
      @(posedge core_clk) #1;
      reg_rd = 1'b0;
      chk({7'h00, reg_rvalid, reg_rdata}, {8'h01, exp});
   endtask
   task automatic results;
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // ****
   // scenarios
   // ****
   task automatic t_rate_codes;
      logic [3:0] codes [6];
      logic [3:0] c;
      codes = '{4'h0, 4'h1, 4'h2, 4'h8, 4'h9, 4'h3};
      repeat (SRC_CLEAR_WAIT) @(posedge core_clk);
      for (int i = 0; i < 4; i++)
         rd(irc_pkg::CONV1_HIGH_RATE_CTRL_OFS + 12'(i), 16'h0000);
      for (int i = 0; i < 6; i++)
      begin
         c = codes[i];
         wr(irc_pkg::CONV1_HIGH_RATE_CTRL_OFS, {1'b1, c, 11'h7ff});
         wr(irc_pkg::CONV1_LOW_RATE_CTRL_OFS, {1'b1, c, 11'h7ff});
         wr(irc_pkg::CONV2_HIGH_RATE_CTRL_OFS, {1'b1, c, 11'h7ff});
         rd(irc_pkg::CONV1_HIGH_RATE_CTRL_OFS, {1'b0, c, 11'h000});
         rd(irc_pkg::CONV1_LOW_RATE_CTRL_OFS, {1'b0, c, 11'h000});
         rd(irc_pkg::CONV2_HIGH_RATE_CTRL_OFS, {1'b0, c, 11'h000});
         chk({12'h000, conv2_high_rate_sel, conv1_cfg.high_rate_sel, conv1_cfg.low_rate_sel},
            {12'h000, c, c, c});
         chk({23'h00_0000, conv1_rate_err}, {23'h00_0000, c == 4'h3});
      end
      // mixed clock domains are flagged, not refused
      wr(irc_pkg::CONV1_HIGH_RATE_CTRL_OFS, 16'h4000);
      wr(irc_pkg::CONV1_LOW_RATE_CTRL_OFS, 16'h0000);
      chk({23'h00_0000, conv1_rate_err}, 24'h00_0001);
   endtask
   task automatic t_enable_bits;
      wr(irc_pkg::CONV1_PATH_ENABLE_CTRL_OFS, 16'hffff);
      rd(irc_pkg::CONV1_PATH_ENABLE_CTRL_OFS, 16'hf3c1);
      chk({15'h0000, conv1_cfg.interp_en, conv1_cfg.decim_en, conv1_cfg.notch_filter_en},
         24'h00_01ff);
      wr(12'h0ef4, 16'h0000);
      rd(12'h0ef4, 16'h0000);
      rd(irc_pkg::CONV1_PATH_ENABLE_CTRL_OFS, 16'hf3c1);
      wr(irc_pkg::CONV1_PATH_ENABLE_CTRL_OFS, 16'h0000);
   endtask
   task automatic t_admission;
      path_src_sel = 64'h0000_0000_0000_0001;
      src_data = {72'h00, 24'h12_3456};
      wr(irc_pkg::CONV1_PATH_ENABLE_CTRL_OFS, 16'h8000);
      @(posedge core_clk) #1;
      chk({16'h0000, path_active}, 24'h00_0001);
      chk(path_data[23:0], 24'h12_3456);
      // another source, then a code past the last source that must feed silence
      path_src_sel = 64'h0000_0000_0000_0003;
      src_data = {24'h00_0000, 24'h65_4321, 24'h00_0000, 24'h12_3456};
      @(posedge core_clk) #1;
      chk(path_data[23:0], 24'h65_4321);
      path_src_sel = 64'h0000_0000_0000_0005;
      @(posedge core_clk) #1;
      chk(path_data[23:0], 24'h00_0000);
      clk_budget_ok = 1'b0;
      wr(irc_pkg::CONV1_PATH_ENABLE_CTRL_OFS, 16'h8200);
      @(posedge core_clk) #1;
      chk({16'h0000, path_active}, 24'h00_0001);
      clk_budget_ok = 1'b1;
      rd(irc_pkg::CONV1_PATH_ENABLE_CTRL_OFS, 16'h8200);
      chk({16'h0000, path_active}, 24'h00_0001);
      wr(irc_pkg::CONV1_PATH_ENABLE_CTRL_OFS, 16'h8000);
      wr(irc_pkg::CONV1_PATH_ENABLE_CTRL_OFS, 16'h8200);
      @(posedge core_clk) #1;
      chk({16'h0000, path_active}, 24'h00_0011);
      chk(path_data[119:96], 24'h00_0000);
      // refused attempt on the first interpolation path
      wr(irc_pkg::CONV1_PATH_ENABLE_CTRL_OFS, 16'h0000);
      clk_budget_ok = 1'b0;
      wr(irc_pkg::CONV1_PATH_ENABLE_CTRL_OFS, 16'h8000);
      @(posedge core_clk) #1;
      chk({16'h0000, path_active}, 24'h00_0000);
      clk_budget_ok = 1'b1;
   endtask
   initial
   begin
      repeat (2) @(posedge core_clk);
      #1;
      rst = 1'b0;
      t_rate_codes();
      t_enable_bits();
      t_admission();
      results();
   end
   // generous bound; the source-select wait plus well under two hundred cycles of scenarios
   initial
   begin
      repeat (20000) @(posedge core_clk);
      miscompares++;
      results();
   end
endmodule
`default_nettype wire
